// ==== hw/tbp_prescaler.sv ====
`include "tbp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tbp_prescaler (
  input wire logic clk_in,
  input wire logic srst_in,
  tbp_gen_if.presc g
);
  logic [1:0] cnt;
  wire logic [1:0] lim = (g.sel == tbp_pkg::sel_div8) ? `TBP_LIM_DIV8 :
    ((g.sel == tbp_pkg::sel_div4) ? `TBP_LIM_DIV4 : 2'h0);

  // One tick per half PWM clock; divide-by-1 steps two half units
  assign g.tick = g.run && (cnt >= lim);
  assign g.step2 = (g.sel == tbp_pkg::sel_div1);

  always_ff @(posedge clk_in) begin
    if (srst_in || !g.run || g.tick) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end

  sequence s_div8_tick;
    g.tick && g.run && (g.sel == tbp_pkg::sel_div8);
  endsequence

  property p_div8;
    @(posedge clk_in) disable iff (srst_in)
    s_div8_tick ##1 (g.run && g.sel == tbp_pkg::sel_div8 && !g.tick)[*3] |=> g.tick;
  endproperty
  a_div8: assert property (p_div8) else $error("div8 tick spacing wrong");

  property p_div2;
    @(posedge clk_in) disable iff (srst_in)
    (g.run && g.sel == tbp_pkg::sel_div2) |-> g.tick && !g.step2;
  endproperty
  a_div2: assert property (p_div2) else $error("div2 half tick missing");

  property p_div4;
    @(posedge clk_in) disable iff (srst_in)
    (g.tick && g.run && g.sel == tbp_pkg::sel_div4) ##1
      (g.run && g.sel == tbp_pkg::sel_div4) |-> !g.tick ##1 g.tick;
  endproperty
  a_div4: assert property (p_div4) else $error("div4 tick spacing wrong");
endmodule
`default_nettype wire

// ==== hw/tbp_top.sv ====
// Notes on behaviour
// - Duty is 10 bits: two high bits in one register, eight in another.
// - Both duty registers are write-only and read back as all ones.
// - Low byte written first; high byte write latches the full value.
// - Latched duty takes effect at the next conversion period boundary.
// - Reset sets the duty register pair to FC00 hex.
// - A conversion period holds four pulses whose high times follow duty.
// - Total high time per period is (duty plus four) half PWM clocks; select 00 rounds each pulse up to a whole PWM clock.
// - Period select 00, 01, 10, 11 gives PWM clock of 1, 2, 4, 8 cycles.
// - Select 11 gives a conversion period of 4096 system cycles.
// - Duty FFFC to FFFF hex holds the output steadily high.
// - Registers reset on device reset, run in active and sleep, else retain.
// - Select 01 divides the system clock by two.
//
// Added by the designer: the address map and the address-and-strobe port.
`include "tbp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tbp_top (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire tbp_pkg::tbp_mode_t op_mode_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic pwm_out
);
  tbp_gen_if gen ();

  tbp_pkg::tbp_sel_t period_sel;
  logic out_en;
  logic [7:0] duty_low_byte;
  logic [1:0] duty_high_bits;
  logic [7:0] latched_low;
  logic pend;
  logic next_pend;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;

  // Operating mode decode
  wire logic func = (op_mode_in == tbp_pkg::mode_active) ||
    (op_mode_in == tbp_pkg::mode_sleep);
  wire logic clr = srst_in || (op_mode_in == tbp_pkg::mode_reset);

  // Register decode; writes outside active and sleep are dropped
  wire logic wr_ok = wr_in && func;
  wire logic wr_ctrl = wr_ok && (addr_in == `TBP_ADDR_CTRL);
  wire logic wr_low = wr_ok && (addr_in == `TBP_ADDR_LOW);
  wire logic wr_high = wr_ok && (addr_in == `TBP_ADDR_HIGH);
  wire logic rd_duty = (addr_in == `TBP_ADDR_LOW) || (addr_in == `TBP_ADDR_HIGH);
  wire logic full_now = tbp_pkg::tbp_is_full(gen.duty);

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`TBP_CTRL_SEL +: 2] = period_sel;
    ctrl_rd[`TBP_CTRL_OE] = out_en;
  end

  always_comb begin
    stat_rd = 8'h00;
    stat_rd[`TBP_STAT_PEND] = pend;
    stat_rd[`TBP_STAT_LEVEL] = pwm_out;
    stat_rd[`TBP_STAT_FULL] = full_now;
  end

  // Duty registers never return their contents
  wire logic [7:0] rd_mux = rd_duty ? `TBP_WO_READ :
    ((addr_in == `TBP_ADDR_CTRL) ? ctrl_rd : stat_rd);

  // A new high write keeps the request alive over a same-cycle hand-off
  assign next_pend = wr_high || (pend && !gen.load_ack);

  // Generator connections
  assign gen.run = func;
  assign gen.sel = period_sel;
  assign gen.load_req = pend;
  assign gen.load_duty = {duty_high_bits, latched_low};

  tbp_prescaler u_presc (
    .clk_in(clk_in),
    .srst_in(clr),
    .g(gen.presc)
  );

  tbp_wave u_wave (
    .clk_in(clk_in),
    .srst_in(clr),
    .g(gen.wave)
  );

  // Control register
  always_ff @(posedge clk_in) begin
    if (clr) begin
      period_sel <= tbp_pkg::tbp_sel_t'(`TBP_CTRL_RST >> `TBP_CTRL_SEL);
      out_en <= 1'(`TBP_CTRL_RST >> `TBP_CTRL_OE);
    end else if (wr_ctrl) begin
      period_sel <= tbp_pkg::tbp_sel_t'(wdata_in[`TBP_CTRL_SEL +: 2]);
      out_en <= wdata_in[`TBP_CTRL_OE];
    end
  end

  // Low byte register
  always_ff @(posedge clk_in) begin
    if (clr) begin
      duty_low_byte <= 8'(`TBP_DUTY_RST);
    end else if (wr_low) begin
      duty_low_byte <= wdata_in;
    end
  end

  // High bits and the latched low byte move together
  always_ff @(posedge clk_in) begin
    if (clr) begin
      duty_high_bits <= 2'(`TBP_DUTY_RST >> 8);
      latched_low <= 8'(`TBP_DUTY_RST);
    end else if (wr_high) begin
      duty_high_bits <= wdata_in[1:0];
      latched_low <= duty_low_byte;
    end
  end

  always_ff @(posedge clk_in) begin
    if (clr) begin
      pend <= 1'b0;
    end else begin
      pend <= next_pend;
    end
  end

  // Read data stands one cycle after the strobe only
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_out <= `TBP_RD_IDLE;
    end else if (rd_in) begin
      rdata_out <= rd_mux;
    end else begin
      rdata_out <= `TBP_RD_IDLE;
    end
  end

  // Output held low while stopped or disabled
  always_ff @(posedge clk_in) begin
    if (clr) begin
      pwm_out <= 1'b0;
    end else begin
      pwm_out <= func && out_en && gen.level;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking

  default disable iff (clr);

  sequence s_high_write;
    wr_in && func && (addr_in == `TBP_ADDR_HIGH);
  endsequence

  sequence s_duty_read;
    rd_in && rd_duty;
  endsequence

  sequence s_frame_load;
    pend ##0 gen.wrap;
  endsequence

  property p_rd_ones;
    s_duty_read |=> (rdata_out == 8'hFF);
  endproperty
  a_rd_ones: assert property (p_rd_ones) else $error("duty read not all ones");

  property p_rd_idle;
    !rd_in |=> (rdata_out == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

  property p_hi_latch;
    s_high_write |=> pend && (gen.load_duty == {$past(wdata_in[1:0]), $past(duty_low_byte)});
  endproperty
  a_hi_latch: assert property (p_hi_latch) else $error("high write did not latch");

  property p_low_only;
    (wr_low && !pend) |=> !pend;
  endproperty
  a_low_only: assert property (p_low_only) else $error("low write started a load");

  property p_frame_load;
    s_frame_load ##0 !wr_high |=> !pend && (gen.duty == $past(gen.load_duty));
  endproperty
  a_frame_load: assert property (p_frame_load) else $error("duty not applied at frame");

  property p_no_early;
    !gen.wrap |=> $stable(gen.duty);
  endproperty
  a_no_early: assert property (p_no_early) else $error("duty changed mid frame");

  property p_reset_val;
    $past(clr) |-> (gen.duty == 10'h000) && (duty_low_byte == 8'h00) &&
      (duty_high_bits == 2'h0);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("duty reset value wrong");

  property p_retain;
    (!func && op_mode_in != tbp_pkg::mode_reset) |=>
      $stable(duty_low_byte) && $stable(duty_high_bits) && $stable(period_sel) &&
      $stable(gen.duty);
  endproperty
  a_retain: assert property (p_retain) else $error("registers changed while retained");

  property p_stopped_low;
    !func |=> !pwm_out;
  endproperty
  a_stopped_low: assert property (p_stopped_low) else $error("output active while stopped");

  property p_full_out;
    (func && out_en && full_now) |=> pwm_out;
  endproperty
  a_full_out: assert property (p_full_out) else $error("full duty output dropped");
endmodule
`default_nettype wire

// ==== hw/tbp_wave.sv ====
`include "tbp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module tbp_wave (
  input wire logic clk_in,
  input wire logic srst_in,
  tbp_gen_if.wave g
);
  logic [9:0] phase;
  logic [9:0] duty;
  logic [10:0] hcnt;
  logic clean;
  wire logic [10:0] total = {1'b0, duty} + `TBP_PAD;
  wire logic [10:0] adv = {1'b0, phase} + (g.step2 ? 11'h002 : 11'h001);
  wire logic wrap = g.tick && adv[10];
  wire logic full = tbp_pkg::tbp_is_full(duty);
  // Remainder units go to the earliest quarters
  wire logic extra = ({1'b0, phase[9:8]} < {1'b0, total[1:0]});
  wire logic [8:0] share = {1'b0, total[9:2]} + {8'h00, extra};
  wire logic level = full || ({1'b0, phase[7:0]} < share);
  wire logic [10:0] inc = (g.tick && level) ? (g.step2 ? 11'h002 : 11'h001) : 11'h000;
  wire logic [10:0] sum_now = hcnt + inc;

  assign g.wrap = wrap;
  assign g.load_ack = wrap && g.load_req;
  assign g.duty = duty;
  assign g.level = level;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase <= 10'h000;
      duty <= 10'(`TBP_DUTY_RST);
    end else begin
      if (g.tick) begin
        phase <= adv[9:0];
      end
      if (wrap && g.load_req) begin
        duty <= g.load_duty;
      end
    end
  end

  // Check helper: high half units seen in the current frame
  always_ff @(posedge clk_in) begin
    if (srst_in || wrap) begin
      hcnt <= 11'h000;
      clean <= 1'b1;
    end else begin
      hcnt <= sum_now;
      clean <= clean && !(g.tick && g.step2);
    end
  end

  property p_high_sum;
    @(posedge clk_in) disable iff (srst_in)
    (wrap && clean && !g.step2 && !full) |-> (sum_now == total);
  endproperty
  a_high_sum: assert property (p_high_sum) else $error("frame high time wrong");

  property p_full;
    @(posedge clk_in) disable iff (srst_in)
    full |-> level;
  endproperty
  a_full: assert property (p_full) else $error("full duty not steady high");
endmodule
`default_nettype wire

// ==== include/tbp_consts.svh ====
`ifndef TBP_CONSTS_SVH
`define TBP_CONSTS_SVH
// Register offsets on the byte bus
`define TBP_ADDR_CTRL 2'h0
`define TBP_ADDR_LOW 2'h1
`define TBP_ADDR_HIGH 2'h2
`define TBP_ADDR_STAT 2'h3
// Control register fields
`define TBP_CTRL_SEL 0
`define TBP_CTRL_OE 2
// Status register fields
`define TBP_STAT_PEND 0
`define TBP_STAT_LEVEL 1
`define TBP_STAT_FULL 2
// Reset values
`define TBP_DUTY_RST 16'hFC00
`define TBP_CTRL_RST 8'h00
// Reads of write-only duty registers
`define TBP_WO_READ 8'hFF
// Idle read data between read strobes
`define TBP_RD_IDLE 8'h00
// High time offset in half clock units
`define TBP_PAD 11'h004
// Lowest duty that forces a steady high level
`define TBP_FULL_MIN 10'h3FC
// Half-unit lengths minus one, in system cycles
`define TBP_LIM_DIV4 2'h1
`define TBP_LIM_DIV8 2'h3
`endif

// ==== include/tbp_gen_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface tbp_gen_if;
  logic run;
  tbp_pkg::tbp_sel_t sel;
  logic tick;
  logic step2;
  logic load_req;
  logic [9:0] load_duty;
  logic load_ack;
  logic [9:0] duty;
  logic level;
  logic wrap;
  modport presc (input run, input sel, output tick, output step2);
  modport wave (input run, input tick, input step2, input load_req, input load_duty,
    output load_ack, output duty, output level, output wrap);
  modport ctl (output run, output sel, output load_req, output load_duty,
    input tick, input load_ack, input duty, input level, input wrap);
endinterface
`default_nettype wire

// ==== include/tbp_pkg.sv ====
package tbp_pkg;
  typedef enum logic [2:0] {
    mode_reset,
    mode_active,
    mode_sleep,
    mode_watch,
    mode_subactive,
    mode_subsleep,
    mode_standby,
    mode_modstandby
  } tbp_mode_t;

  typedef enum logic [1:0] {
    sel_div1,
    sel_div2,
    sel_div4,
    sel_div8
  } tbp_sel_t;

  function automatic logic tbp_is_full(input logic [9:0] duty);
    return duty >= 10'h3FC;
  endfunction
endpackage

// ==== verif/tb_ten_bit_pwm_generator.sv ====
`include "tbp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
`define check_eq(name, exp, got) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", name, exp, got); \
  end \
end
module tb_ten_bit_pwm_generator;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  tbp_pkg::tbp_mode_t op_mode_in = tbp_pkg::mode_active;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] rdata_out;
  logic pwm_out;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [31:0] lfsr = 32'h0861;
  int m_ctrl = 0;
  int m_low = 0;
  int m_next = 0;
  int m_duty = 0;
  int hi;
  int rises;
  int duty;
  logic [7:0] d;

  tbp_top dut (.clk_in(clk_in), .srst_in(srst_in), .op_mode_in(op_mode_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pwm_out(pwm_out));

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // High cycles per frame: quarters share duty+4 half units evenly
  function automatic int exp_hi(input int sel, input int dv);
    int t;
    int hq;
    int s;
    t = dv + 4;
    s = 0;
    for (int q = 0; q < 4; q++) begin
      hq = t / 4 + ((q < t % 4) ? 1 : 0);
      s += (sel == 0) ? (hq + 1) / 2 : hq << (sel - 1);
    end
    return s;
  endfunction

  task automatic bus_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    if (op_mode_in == tbp_pkg::mode_active || op_mode_in == tbp_pkg::mode_sleep) begin
      if (a == `TBP_ADDR_CTRL) m_ctrl = v & 8'h07;
      if (a == `TBP_ADDR_LOW) m_low = v;
      if (a == `TBP_ADDR_HIGH) m_next = (v & 8'h03) * 256 + m_low;
    end
  endtask

  task automatic bus_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    v = rdata_out;
  endtask

  task automatic set_duty(input int dv);
    bus_wr(`TBP_ADDR_LOW, dv[7:0]);
    bus_rd(`TBP_ADDR_STAT, d);
    `check_eq("pend after low", 0, d & 8'h01)
    bus_wr(`TBP_ADDR_HIGH, {6'h00, dv[9:8]});
    bus_rd(`TBP_ADDR_STAT, d);
    `check_eq("pend after high", 1, d & 8'h01)
    for (int i = 0; i < 3000 && d[0] !== 1'b0; i++) bus_rd(`TBP_ADDR_STAT, d);
    m_duty = m_next;
    `check_eq("status", (m_duty >= 16'h03FC) ? 4 : 0, d & 8'h05)
  endtask

  task automatic measure(input int frame);
    logic prev;
    repeat (4) @(posedge clk_in);
    #1;
    prev = pwm_out;
    hi = 0;
    rises = 0;
    repeat (frame) begin
      @(posedge clk_in);
      #1;
      if (pwm_out === 1'b1) hi++;
      if (pwm_out === 1'b1 && prev !== 1'b1) rises++;
      prev = pwm_out;
    end
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge clk_in);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    srst_in <= 1'b0;
    bus_rd(`TBP_ADDR_CTRL, d);
    `check_eq("ctrl reset", 0, d)
    bus_rd(`TBP_ADDR_LOW, d);
    `check_eq("low read", 8'hFF, d)
    bus_rd(`TBP_ADDR_HIGH, d);
    `check_eq("high read", 8'hFF, d)
    bus_rd(`TBP_ADDR_STAT, d);
    `check_eq("status reset", 0, d)
    bus_wr(`TBP_ADDR_CTRL, 8'hFD);
    bus_rd(`TBP_ADDR_CTRL, d);
    `check_eq("ctrl back", m_ctrl, d)
    measure(1024);
    `check_eq("reset high time", exp_hi(1, 0), hi)
    `check_eq("reset pulses", 4, rises)
    $display("reset test done");
    for (int sel = 0; sel < 4; sel++) begin
      op_mode_in <= (sel == 2) ? tbp_pkg::mode_sleep : tbp_pkg::mode_active;
      bus_wr(`TBP_ADDR_CTRL, 8'h04 | sel[7:0]);
      lfsr = lfsr_next(lfsr);
      duty = lfsr % 1020;
      set_duty(duty);
      measure(512 << sel);
      `check_eq("high time", exp_hi(sel, duty), hi)
      `check_eq("pulses", 4, rises)
      $display("select %0d test done", sel);
    end
    op_mode_in <= tbp_pkg::mode_active;
    bus_wr(`TBP_ADDR_CTRL, 8'h05);
    for (int v = 16'h03FC; v <= 16'h03FF; v++) begin
      set_duty(v);
      measure(1024);
      `check_eq("full high time", 1024, hi)
      `check_eq("full pulses", 0, rises)
    end
    $display("full level test done");
    for (int m = 3; m < 8; m++) begin
      op_mode_in <= tbp_pkg::tbp_mode_t'(m);
      lfsr = lfsr_next(lfsr);
      bus_wr(`TBP_ADDR_CTRL, lfsr[7:0]);
      bus_wr(`TBP_ADDR_HIGH, lfsr[15:8]);
      bus_rd(`TBP_ADDR_CTRL, d);
      `check_eq("ctrl retained", m_ctrl, d)
      bus_rd(`TBP_ADDR_STAT, d);
      `check_eq("pend retained", 0, d & 8'h01)
      `check_eq("output in retain", 1'b0, pwm_out)
    end
    $display("retain test done");
    op_mode_in <= tbp_pkg::mode_reset;
    repeat (3) @(posedge clk_in);
    op_mode_in <= tbp_pkg::mode_active;
    m_ctrl = 0;
    m_low = 0;
    m_duty = 0;
    bus_rd(`TBP_ADDR_CTRL, d);
    `check_eq("ctrl mode reset", m_ctrl, d)
    bus_wr(`TBP_ADDR_CTRL, 8'h05);
    measure(1024);
    `check_eq("mode reset high time", exp_hi(1, m_duty), hi)
    $display("mode reset test done");
    give_verdict();
  end
endmodule
`default_nettype wire
